// [rtl/spe_consts.vh]
// constants for the port 2 serial error interrupt-pending block
// assumes inclusion by bare name from the design file
`ifndef SPE_CONSTS_VH
`define SPE_CONSTS_VH

// ****************************************
// serial error register bit positions
// ****************************************
`define SPE_SERR_WIDTH 32
`define SPE_SERR_LINK_READY 1
`define SPE_SERR_DATA_INTEG 8
`define SPE_SERR_UNREC_FRAME 10
`define SPE_SERR_FIFO_ERR 11
`define SPE_SERR_LINK_CHANGE 16
`define SPE_SERR_ERR_PRIM 22

// ****************************************
// pending register bit positions
// ****************************************
`define SPE_PEND_WIDTH 32
`define SPE_PEND_LINK_CHANGE 16
`define SPE_PEND_LINK_READY 17
`define SPE_PEND_FIFO_ERR 18
`define SPE_PEND_ERR_PRIM 19
`define SPE_PEND_UNREC_FRAME 20
`define SPE_PEND_DATA_INTEG 21

// ****************************************
// reset values
// ****************************************
`define SPE_PEND_RESET 32'h0000_0000
`define SPE_SERR_RESET 32'h0000_0000
`define SPE_FLAG_RESET 1'h0
`define SPE_LINK_IDLE 1'h0

`endif

// [rtl/spe_pending.v]
// port 2 serial error interrupt-pending bits, set by latched events
// assumes event pulses and write-one-to-clear strobes on sys_clk_i
`timescale 1ns/1ps
`include "spe_consts.vh"

module spe_pending (
   // clock and reset
   input wire sys_clk_i,
   input wire rst_b_i,
   // hardware events, one-cycle pulses
   input wire data_integ_evt_i,
   input wire unrec_frame_evt_i,
   input wire err_prim_evt_i,
   input wire fifo_err_evt_i,
   // link ready level from the link layer, same clock
   input wire link_ready_i,
   // software write-one-to-clear on the serial error register
   input wire serr_wr_i,
   input wire [`SPE_SERR_WIDTH-1:0] serr_wdata_i,
   // status
   output wire [`SPE_SERR_WIDTH-1:0] port_serial_error_register_o,
   output wire [`SPE_PEND_WIDTH-1:0] pend_o,
   output wire handshake_error_primitive_flag_o,
   output wire link_state_change_flag_o
);

   // ****************************************
   // local sizes
   // ****************************************
   localparam SW = `SPE_SERR_WIDTH;
   localparam PW = `SPE_PEND_WIDTH;

   // ****************************************
   // declarations
   // ****************************************
   wire link_rise;
   wire link_fall;
   wire link_change;

   wire set_data_integ;
   wire set_unrec_frame;
   wire set_err_prim;
   wire set_fifo_err;
   wire set_link_ready;
   wire set_link_change;

   wire clr_data_integ;
   wire clr_unrec_frame;
   wire clr_err_prim;
   wire clr_fifo_err;
   wire clr_link_ready;
   wire clr_link_change;

   wire flag_data_integ;
   wire flag_unrec_frame;
   wire flag_err_prim;
   wire flag_fifo_err;
   wire flag_link_ready;
   wire flag_link_change;

   reg [SW-1:0] serr_v;
   reg [PW-1:0] pend_v;

   // ****************************************
   // link level edges
   // ****************************************
   spe_edge_det #(
      .IDLE_VAL(`SPE_LINK_IDLE)
   ) link_edge_u (
      .clk_i(sys_clk_i),
      .rst_b_i(rst_b_i),
      .level_i(link_ready_i),
      .rise_o(link_rise),
      .fall_o(link_fall)
   );
   assign link_change = link_rise | link_fall;

   // ****************************************
   // set requests
   // ****************************************
   assign set_data_integ = data_integ_evt_i;
   assign set_unrec_frame = unrec_frame_evt_i;
   assign set_err_prim = err_prim_evt_i;
   assign set_fifo_err = fifo_err_evt_i;
   assign set_link_ready = link_rise;
   assign set_link_change = link_change;

   // ****************************************
   // write-one-to-clear requests
   // ****************************************
   // ones in unused bit positions are simply ignored
   assign clr_data_integ = serr_wr_i & serr_wdata_i[`SPE_SERR_DATA_INTEG];
   assign clr_unrec_frame = serr_wr_i & serr_wdata_i[`SPE_SERR_UNREC_FRAME];
   assign clr_err_prim = serr_wr_i & serr_wdata_i[`SPE_SERR_ERR_PRIM];
   assign clr_fifo_err = serr_wr_i & serr_wdata_i[`SPE_SERR_FIFO_ERR];
   assign clr_link_ready = serr_wr_i & serr_wdata_i[`SPE_SERR_LINK_READY];
   assign clr_link_change = serr_wr_i & serr_wdata_i[`SPE_SERR_LINK_CHANGE];

   // ****************************************
   // data integrity flag
   // ****************************************
   // crc and disparity fold into this one flag; error primitives have their own flag
   spe_sticky_bit #(
      .RESET_VAL(`SPE_FLAG_RESET)
   ) integ_u (
      .clk_i(sys_clk_i),
      .rst_b_i(rst_b_i),
      .set_i(set_data_integ),
      .clr_i(clr_data_integ),
      .flag_o(flag_data_integ)
   );

   // ****************************************
   // unrecognised frame flag
   // ****************************************
   // raised by the frame decoder, never by the link
   spe_sticky_bit #(
      .RESET_VAL(`SPE_FLAG_RESET)
   ) frame_u (
      .clk_i(sys_clk_i),
      .rst_b_i(rst_b_i),
      .set_i(set_unrec_frame),
      .clr_i(clr_unrec_frame),
      .flag_o(flag_unrec_frame)
   );

   // ****************************************
   // received error primitive flag
   // ****************************************
   // only meaningful during a data frame; qualified upstream
   spe_sticky_bit #(
      .RESET_VAL(`SPE_FLAG_RESET)
   ) prim_u (
      .clk_i(sys_clk_i),
      .rst_b_i(rst_b_i),
      .set_i(set_err_prim),
      .clr_i(clr_err_prim),
      .flag_o(flag_err_prim)
   );

   // ****************************************
   // fifo error flag
   // ****************************************
   // a level held high re-sets the flag every cycle
   spe_sticky_bit #(
      .RESET_VAL(`SPE_FLAG_RESET)
   ) fifo_u (
      .clk_i(sys_clk_i),
      .rst_b_i(rst_b_i),
      .set_i(set_fifo_err),
      .clr_i(clr_fifo_err),
      .flag_o(flag_fifo_err)
   );

   // ****************************************
   // link ready flag
   // ****************************************
   // sticky from the rise, not a live copy of the level
   spe_sticky_bit #(
      .RESET_VAL(`SPE_FLAG_RESET)
   ) ready_u (
      .clk_i(sys_clk_i),
      .rst_b_i(rst_b_i),
      .set_i(set_link_ready),
      .clr_i(clr_link_ready),
      .flag_o(flag_link_ready)
   );

   // ****************************************
   // link state change flag
   // ****************************************
   // both directions of the link level land here
   spe_sticky_bit #(
      .RESET_VAL(`SPE_FLAG_RESET)
   ) change_u (
      .clk_i(sys_clk_i),
      .rst_b_i(rst_b_i),
      .set_i(set_link_change),
      .clr_i(clr_link_change),
      .flag_o(flag_link_change)
   );

   // ****************************************
   // serial error word
   // ****************************************
   always @* begin
      serr_v = `SPE_SERR_RESET;
      serr_v[`SPE_SERR_DATA_INTEG] = flag_data_integ;
      serr_v[`SPE_SERR_UNREC_FRAME] = flag_unrec_frame;
      serr_v[`SPE_SERR_ERR_PRIM] = flag_err_prim;
      serr_v[`SPE_SERR_FIFO_ERR] = flag_fifo_err;
      serr_v[`SPE_SERR_LINK_READY] = flag_link_ready;
      serr_v[`SPE_SERR_LINK_CHANGE] = flag_link_change;
   end

   // ****************************************
   // pending word, pure wiring of the flags
   // ****************************************
   always @* begin
      pend_v = `SPE_PEND_RESET;
      pend_v[`SPE_PEND_DATA_INTEG] = flag_data_integ;
      pend_v[`SPE_PEND_UNREC_FRAME] = flag_unrec_frame;
      pend_v[`SPE_PEND_ERR_PRIM] = flag_err_prim;
      pend_v[`SPE_PEND_FIFO_ERR] = flag_fifo_err;
      pend_v[`SPE_PEND_LINK_READY] = flag_link_ready;
      pend_v[`SPE_PEND_LINK_CHANGE] = flag_link_change;
   end

   // ****************************************
   // outputs
   // ****************************************
   assign pend_o = pend_v;
   assign port_serial_error_register_o = serr_v;
   assign handshake_error_primitive_flag_o = flag_err_prim;
   assign link_state_change_flag_o = flag_link_change;

endmodule

// ****************************************
// one sticky flag
// ****************************************
module spe_sticky_bit #(
   parameter [0:0] RESET_VAL = 1'b0
) (
   // clock and reset
   input wire clk_i,
   input wire rst_b_i,
   // set and clear requests
   input wire set_i,
   input wire clr_i,
   // sticky state
   output wire flag_o
);

   reg flag_q;
   reg flag_d;

   // ****************************************
   // next state
   // ****************************************
   // set wins over a same-cycle clear so no event is lost
   always @* begin
      flag_d = flag_q;
      if (set_i) begin
         flag_d = 1'b1;
      end else if (clr_i) begin
         flag_d = 1'b0;
      end
   end

   // ****************************************
   // state flop
   // ****************************************
   always @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         flag_q <= RESET_VAL;
      end else begin
         flag_q <= flag_d;
      end
   end

   assign flag_o = flag_q;

endmodule

// ****************************************
// level edge detector on the same clock
// ****************************************
module spe_edge_det #(
   parameter [0:0] IDLE_VAL = 1'b0
) (
   // clock and reset
   input wire clk_i,
   input wire rst_b_i,
   // watched level
   input wire level_i,
   // edge strobes
   output wire rise_o,
   output wire fall_o
);

   reg level_q;

   // ****************************************
   // previous level
   // ****************************************
   // idle value after reset, so a level already high at release is a rise
   always @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         level_q <= IDLE_VAL;
      end else begin
         level_q <= level_i;
      end
   end

   assign rise_o = level_i & ~level_q;
   assign fall_o = ~level_i & level_q;

endmodule

// [test/spe_pending_assertions.sv]
// checker on spe_pending ports; bound below
`timescale 1ns/1ps
module spe_chk(input wire sys_clk_i,input wire rst_b_i,
input wire data_integ_evt_i,input wire unrec_frame_evt_i,
input wire err_prim_evt_i,input wire fifo_err_evt_i,input wire link_ready_i,
input wire serr_wr_i,input wire [31:0] serr_wdata_i,input wire [31:0] pend_o,
input wire handshake_error_primitive_flag_o,input wire link_state_change_flag_o);
default clocking @(posedge sys_clk_i); endclocking
default disable iff (!rst_b_i);
integ_set_a: assert property (data_integ_evt_i|=>pend_o[21])
else $error("b21 unset");
integ_hold_a: assert property (pend_o[21]&&!(serr_wr_i&&serr_wdata_i[8])
|=>pend_o[21]) else $error("b21 lost");
frame_set_a: assert property (unrec_frame_evt_i|=>pend_o[20])
else $error("b20 unset");
prim_set_a: assert property (err_prim_evt_i|=>pend_o[19]&&
handshake_error_primitive_flag_o) else $error("b19 unset");
fifo_set_a: assert property (fifo_err_evt_i|=>pend_o[18])
else $error("b18 unset");
fifo_clr_a: assert property (serr_wr_i&&serr_wdata_i[11]&&!fifo_err_evt_i
|=>!pend_o[18]) else $error("b18 kept");
prim_clr_a: assert property (serr_wr_i&&serr_wdata_i[22]&&!err_prim_evt_i
|=>!pend_o[19]) else $error("b19 kept");
rdy_clr_a: assert property (serr_wr_i&&serr_wdata_i[1]&&!$rose(link_ready_i)
|=>!pend_o[17]) else $error("b17 kept");
rdy_set_a: assert property ($rose(link_ready_i)|=>pend_o[17])
else $error("b17 unset");
link_chg_a: assert property ($changed(link_ready_i)|=>
link_state_change_flag_o&&pend_o[16]) else $error("b16 unset");
endmodule
bind spe_pending spe_chk chk_u(.*);

// [test/spe_drv.sv]
// drive-side model: event pulses and link ready level
`timescale 1ns/1ps
module spe_drv(input wire clk,output reg [3:0] evt,output reg rdy);
initial begin evt=0; rdy=0; end
task pulse(input [3:0] m); begin @(negedge clk) evt=m;
@(negedge clk) evt=0; end endtask
task link(input v); @(negedge clk) rdy=v; endtask
endmodule

// [test/spe_pending_tb.sv]
// bench: events from spe_drv, write-one clears, pend_o checked
`timescale 1ns/1ps
module spe_pending_tb;
reg clk=0,rst_b=0,wr=0; reg [31:0] wd=0,m; wire [3:0] ev; wire rdy;
wire [31:0] pend,serr; wire hf,lf; integer error_cnt=0,samples_checked=0,i;
initial forever #10 clk=~clk;
spe_drv drv_u(.clk(clk),.evt(ev),.rdy(rdy));
spe_pending dut_u(.sys_clk_i(clk),.rst_b_i(rst_b),.data_integ_evt_i(ev[0]),
.unrec_frame_evt_i(ev[1]),.err_prim_evt_i(ev[2]),.fifo_err_evt_i(ev[3]),
.link_ready_i(rdy),.serr_wr_i(wr),.serr_wdata_i(wd),.pend_o(pend),
.port_serial_error_register_o(serr),.handshake_error_primitive_flag_o(hf),
.link_state_change_flag_o(lf));
task chk(input [31:0] s,e); begin samples_checked=samples_checked+1;
if(s!==e) begin error_cnt=error_cnt+1;
$display("[ERR] %0t pend %h exp %h",$time,s,e); end end endtask
task clr(input [31:0] c); begin @(negedge clk) begin wr=1; wd=c; end
@(negedge clk) wr=0; end endtask
task report_and_stop; begin
$display("checks %0d mismatches %0d",samples_checked,error_cnt);
if(error_cnt==0&&samples_checked>0) $display("NO MISMATCHES");
else $display("MISMATCHES SEEN");
$finish; end endtask
initial begin
repeat(16) @(negedge clk); rst_b=1;
chk(pend,0);
for(i=0;i<4;i=i+1) begin
m=i==0?1<<8:i==1?1<<10:i==2?1<<22:1<<11;
drv_u.pulse(1<<i); chk(pend,32'h0020_0000>>i);
chk(serr,m);
chk({30'h0,lf,hf},i==2?1:0);
clr(~m); chk(pend,32'h0020_0000>>i);
clr(m); chk(pend,0);
$display("event %0d done",i); end
fork drv_u.pulse(8); clr(1<<11); join
chk(pend,32'h0004_0000);
clr(1<<11); chk(pend,0);
$display("set wins done");
drv_u.link(1); @(negedge clk) chk(pend,32'h0003_0000);
chk(serr,32'h0001_0002);
chk({30'h0,lf,hf},2);
clr(2); chk(pend,32'h0001_0000);
clr(1<<16); drv_u.link(0); @(negedge clk) chk(pend,32'h0001_0000);
$display("link done"); report_and_stop;
end
endmodule
